// ---- hw/power_good_top.sv ----
// power-good qualifier, reference clock selection and switch timing
// assumes the sense code comes from an adc clocked by the core clock;
// sync, shutdown, lockout and current trip are asynchronous pins
`timescale 1ns/1ns
`default_nettype none
module power_good_top
	import power_ok_flag_pkg::*;
(
	input  wire logic              CORE_CLK_IN,
	input  wire logic              RESETN_IN,
	input  wire logic [SENSE_W-1:0] FEEDBACK_SENSE_IN,
	input  wire logic              SYNC_IN,
	input  wire logic              SHUTDOWN_N_IN,
	input  wire logic              UVLO_CLEAR_IN,
	input  wire logic              CURRENT_TRIP_IN,
	output var  logic              POWER_OK_FLAG_O_OUT,
	output var  logic              POWER_OK_FLAG_OE_OUT,
	output var  logic              INVERTED_CLOCK_O_OUT,
	output var  logic              INVERTED_CLOCK_OE_OUT,
	output var  logic              HIGH_SIDE_ON_OUT,
	output var  logic              LOW_SIDE_ON_OUT,
	output var  logic              SWITCH_OE_OUT,
	output var  logic              EXT_SYNC_OUT
);

	// --------------------------------
	// pin synchronisers
	// --------------------------------
	logic [3:0] meta_r;
	logic [3:0] sync_r;
	logic       sync_lvl;
	logic       shdn_n;
	logic       uvlo_ok;
	logic       trip;

	// two stages on every pin; the first stage feeds only the second
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			meta_r <= 4'h0;
			sync_r <= 4'h0;
		end else begin
			meta_r <= {CURRENT_TRIP_IN, UVLO_CLEAR_IN, SHUTDOWN_N_IN, SYNC_IN};
			sync_r <= meta_r;
		end
	end
	assign sync_lvl = sync_r[0];
	assign shdn_n   = sync_r[1];
	assign uvlo_ok  = sync_r[2];
	assign trip     = sync_r[3];

	// --------------------------------
	// enable gating
	// --------------------------------
	logic enable_r;

	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			enable_r <= 1'b0;
		end else begin
			enable_r <= shdn_n & uvlo_ok;
		end
	end

	// --------------------------------
	// sync activity detection
	// --------------------------------
	logic              sync_prev_r;
	logic              sync_rise;
	logic [TMR_W-1:0]  per_r;
	logic              per_ok_r;
	ref_mode_t         mode_r;

	assign sync_rise = sync_lvl & ~sync_prev_r;

	// measures rising-edge spacing; a timeout drops back to the oscillator
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			sync_prev_r <= 1'b0;
			per_r       <= '0;
			per_ok_r    <= 1'b0;
			mode_r      <= REF_INTERNAL;
		end else begin
			sync_prev_r <= sync_lvl;
			if (sync_rise) begin
				per_r    <= '0;
				per_ok_r <= (per_r >= TMR_W'(SYNC_MIN_CYC - 1)) && (per_r < TMR_W'(SYNC_MAX_CYC));
				// two good periods in a row are needed to lock
				if (per_ok_r && per_r >= TMR_W'(SYNC_MIN_CYC - 1) && per_r < TMR_W'(SYNC_MAX_CYC)) begin
					mode_r <= REF_EXTERNAL;
				end else begin
					mode_r <= REF_INTERNAL;
				end
			end else if (per_r >= TMR_W'(SYNC_MAX_CYC)) begin
				per_ok_r <= 1'b0;
				mode_r   <= REF_INTERNAL;  // a static pin is a strap
			end else begin
				per_r <= per_r + 1'b1;
			end
		end
	end

	// --------------------------------
	// internal oscillator
	// --------------------------------
	logic [TMR_W-1:0] osc_r;
	logic [TMR_W-1:0] osc_period;
	logic             osc_clk;

	// a static-high or open pin gives the fast rate
	assign osc_period = sync_lvl ? TMR_W'(OSC_FAST_CYC) : TMR_W'(OSC_SLOW_CYC);
	assign osc_clk    = osc_r < (osc_period >> 1);

	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			osc_r <= '0;
		end else if (osc_r >= osc_period - 1'b1) begin
			osc_r <= '0;
		end else begin
			osc_r <= osc_r + 1'b1;
		end
	end

	// --------------------------------
	// reference clock and its edges
	// --------------------------------
	logic ref_r;
	logic ref_prev_r;
	logic ref_rise;
	logic ref_fall;

	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			ref_r      <= 1'b0;
			ref_prev_r <= 1'b0;
		end else begin
			ref_r      <= (mode_r == REF_EXTERNAL) ? sync_lvl : osc_clk;
			ref_prev_r <= ref_r;
		end
	end
	assign ref_rise = ref_r & ~ref_prev_r;
	assign ref_fall = ~ref_r & ref_prev_r;

	// --------------------------------
	// window comparator with hysteresis
	// --------------------------------
	logic in_window_r;

	// wider exit limits keep the flag from chattering at the edge
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			in_window_r <= 1'b0;
		end else if (in_window_r) begin
			in_window_r <= (FEEDBACK_SENSE_IN >= WIN_LO_EXIT) && (FEEDBACK_SENSE_IN <= WIN_HI_EXIT);
		end else begin
			in_window_r <= (FEEDBACK_SENSE_IN >= WIN_LO_ENTER) && (FEEDBACK_SENSE_IN <= WIN_HI_ENTER);
		end
	end

	// --------------------------------
	// power-good qualifier
	// --------------------------------
	logic power_ok;

	window_qualifier u_qual (
		.clk_in       (CORE_CLK_IN),
		.rst_n_in     (RESETN_IN),
		.disable_in   (~enable_r),
		.tick_in      (ref_rise),
		.in_window_in (in_window_r),
		.ok_out       (power_ok)
	);

	// --------------------------------
	// open-drain outputs
	// --------------------------------
	// pulling low means not good; released means good
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			POWER_OK_FLAG_O_OUT   <= 1'b0;
			POWER_OK_FLAG_OE_OUT  <= 1'b1;
			INVERTED_CLOCK_O_OUT  <= 1'b0;
			INVERTED_CLOCK_OE_OUT <= 1'b0;
			EXT_SYNC_OUT          <= 1'b0;
		end else begin
			POWER_OK_FLAG_O_OUT   <= 1'b0;
			POWER_OK_FLAG_OE_OUT  <= ~power_ok;
			INVERTED_CLOCK_O_OUT  <= 1'b0;
			INVERTED_CLOCK_OE_OUT <= ref_r;
			EXT_SYNC_OUT          <= (mode_r == REF_EXTERNAL);
		end
	end

	// --------------------------------
	// switch timing
	// --------------------------------
	// high side from each reference falling edge until the current trips;
	// low side holds until the next falling edge (continuous conduction)
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			HIGH_SIDE_ON_OUT <= 1'b0;
			LOW_SIDE_ON_OUT  <= 1'b0;
			SWITCH_OE_OUT    <= 1'b0;
		end else if (!enable_r) begin
			HIGH_SIDE_ON_OUT <= 1'b0;
			LOW_SIDE_ON_OUT  <= 1'b0;
			SWITCH_OE_OUT    <= 1'b0;
		end else if (ref_fall) begin
			HIGH_SIDE_ON_OUT <= 1'b1;
			LOW_SIDE_ON_OUT  <= 1'b0;
			SWITCH_OE_OUT    <= 1'b1;
		end else if (HIGH_SIDE_ON_OUT && trip) begin
			HIGH_SIDE_ON_OUT <= 1'b0;
			LOW_SIDE_ON_OUT  <= 1'b1;
			SWITCH_OE_OUT    <= 1'b1;
		end else begin
			SWITCH_OE_OUT    <= SWITCH_OE_OUT;
		end
	end

endmodule
`default_nettype wire

// ---- include/power_ok_flag_pkg.sv ----
// constants for the power-good qualifier and reference clock selector
// assumes a 125 MHz core clock and a feedback sense code in millivolts
//
// How it works
// - in window within ten percent of 1V
// - sixty-four in-window reference cycles assert flag
// - early window exit clears count, flag stays low
// - sixty-four out-of-window cycles deassert flag
// - window return clears count, flag stays high
// - flag is an open-drain output
// - sync strap high 1 MHz, low 500 kHz
// - toggling sync 100 kHz-5 MHz becomes reference
// - open-drain output carries inverted reference clock
// - reference clock times switching and counter
// - reference falling edge turns high side on
// - shutdown or lockout tri-states switch output
package power_ok_flag_pkg;

	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CORE_PERIOD_NS   = 8;
	localparam int OSC_FAST_NS      = 1000;   // 1 MHz period
	localparam int OSC_SLOW_NS      = 2000;   // 500 kHz period
	localparam int SYNC_MIN_NS      = 200;    // 5 MHz period
	localparam int SYNC_MAX_NS      = 10000;  // 100 kHz period
	localparam int OSC_FAST_CYC     = OSC_FAST_NS / CORE_PERIOD_NS;
	localparam int OSC_SLOW_CYC     = OSC_SLOW_NS / CORE_PERIOD_NS;
	localparam int SYNC_MIN_CYC     = (SYNC_MIN_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	localparam int SYNC_MAX_CYC     = SYNC_MAX_NS / CORE_PERIOD_NS;
	localparam int TMR_W            = 12;

	// ----------------------------------------
	// window thresholds in millivolts
	// ----------------------------------------
	localparam int SENSE_W          = 12;
	localparam logic [11:0] WIN_LO_ENTER = 12'h384;  // 900 mV
	localparam logic [11:0] WIN_HI_ENTER = 12'h44c;  // 1100 mV
	localparam logic [11:0] WIN_LO_EXIT  = 12'h366;  // 870 mV, 30 mV hysteresis
	localparam logic [11:0] WIN_HI_EXIT  = 12'h46a;  // 1130 mV

	// ----------------------------------------
	// qualifier
	// ----------------------------------------
	localparam int QUAL_W           = 7;
	localparam logic [6:0] QUAL_COUNT = 7'h40;       // 64 reference cycles
	localparam logic [6:0] QUAL_RESET = 7'h00;

	typedef enum logic [1:0] {REF_INTERNAL, REF_EXTERNAL} ref_mode_t;

endpackage

// ---- hw/window_qualifier.sv ----
// power-good debounce counter in both directions
// assumes tick_in is a one-cycle pulse per reference clock cycle
`timescale 1ns/1ns
`default_nettype none
module window_qualifier
	import power_ok_flag_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic disable_in,
	input  wire logic tick_in,
	input  wire logic in_window_in,
	output var  logic ok_out
);

	logic [QUAL_W-1:0] cnt_r;
	logic              ok_r;
	logic              moving;

	// the count only runs while the window state disagrees with the flag
	assign moving = ok_r ? ~in_window_in : in_window_in;
	assign ok_out = ok_r;

	// --------------------------------
	// counter and flag
	// --------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_r <= QUAL_RESET;
			ok_r  <= 1'b0;
		end else if (disable_in) begin
			cnt_r <= QUAL_RESET;
			ok_r  <= 1'b0;
		end else if (!moving) begin
			cnt_r <= QUAL_RESET;
		end else if (tick_in) begin
			if (cnt_r == QUAL_COUNT - 7'h01) begin
				cnt_r <= QUAL_RESET;
				ok_r  <= ~ok_r;
			end else begin
				cnt_r <= cnt_r + 7'h01;
			end
		end
	end

endmodule
`default_nettype wire

// ---- verification/power_good_sva.sv ----
// port checker for power_good_top
// bound onto the top module; one clock, async low reset
`timescale 1ns/1ns
`default_nettype none
module power_good_sva
	import power_ok_flag_pkg::*;
(
	input wire logic               CORE_CLK_IN,
	input wire logic               RESETN_IN,
	input wire logic [SENSE_W-1:0] FEEDBACK_SENSE_IN,
	input wire logic               SYNC_IN,
	input wire logic               SHUTDOWN_N_IN,
	input wire logic               UVLO_CLEAR_IN,
	input wire logic               CURRENT_TRIP_IN,
	input wire logic               POWER_OK_FLAG_O_OUT,
	input wire logic               POWER_OK_FLAG_OE_OUT,
	input wire logic               INVERTED_CLOCK_O_OUT,
	input wire logic               INVERTED_CLOCK_OE_OUT,
	input wire logic               HIGH_SIDE_ON_OUT,
	input wire logic               SWITCH_OE_OUT,
	input wire logic               EXT_SYNC_OUT
);
	// ----
	// run lengths
	// ----
	logic [11:0] in_r, out_r, idle_r, hi_r;
	logic        sync_r;
	wire         in_win = FEEDBACK_SENSE_IN >= WIN_LO_EXIT && FEEDBACK_SENSE_IN <= WIN_HI_EXIT;
	// saturate so long waits never wrap back to small counts
	function automatic logic [11:0] inc(input logic c, input logic [11:0] v);
		return !c ? 12'h000 : (v == 12'hfff ? v : v + 12'h001);
	endfunction
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			in_r <= 12'h000;
			out_r <= 12'h000;
			idle_r <= 12'h000;
			hi_r <= 12'h000;
			sync_r <= 1'b0;
		end else begin
			in_r <= inc(in_win, in_r);
			out_r <= inc(!in_win, out_r);
			idle_r <= inc(SYNC_IN == sync_r, idle_r);
			hi_r <= inc(INVERTED_CLOCK_OE_OUT, hi_r);
			sync_r <= SYNC_IN;
		end
	end
	default clocking cb @(posedge CORE_CLK_IN); endclocking
	default disable iff (!RESETN_IN);
	// 64 reference periods are at least 1575 core cycles even at 5 MHz
	a_flag_data_low: assert property (POWER_OK_FLAG_O_OUT == 1'b0) else $error("flag data high");
	a_clk_data_low: assert property (INVERTED_CLOCK_O_OUT == 1'b0) else $error("clock data high");
	a_good_needs_window: assert property ($fell(POWER_OK_FLAG_OE_OUT) |-> in_r >= 12'h627)
		else $error("flag good too soon");
	a_bad_needs_exit: assert property ($rose(POWER_OK_FLAG_OE_OUT) && SHUTDOWN_N_IN && UVLO_CLEAR_IN
		|-> out_r >= 12'h627) else $error("flag dropped too soon");
	a_osc_half_period: assert property ($fell(INVERTED_CLOCK_OE_OUT) && idle_r == 12'hfff
		|-> hi_r inside {[12'h03d:12'h03f], [12'h07c:12'h07e]}) else $error("bad osc phase");
	a_ext_needs_toggle: assert property (EXT_SYNC_OUT |-> idle_r < 12'h4f6) else $error("ext lock idle");
	a_start_on_fall: assert property ($fell(INVERTED_CLOCK_OE_OUT) && SWITCH_OE_OUT && !CURRENT_TRIP_IN
		|-> ##[0:3] HIGH_SIDE_ON_OUT) else $error("no high side on");
	a_start_ref_low: assert property ($rose(HIGH_SIDE_ON_OUT) |-> !INVERTED_CLOCK_OE_OUT)
		else $error("start off ref low");
	a_off_clears_flag: assert property ((!SHUTDOWN_N_IN || !UVLO_CLEAR_IN) [*8]
		|-> POWER_OK_FLAG_OE_OUT) else $error("flag good when off");
	a_off_tristates: assert property (!SHUTDOWN_N_IN [*6] |-> !SWITCH_OE_OUT && !HIGH_SIDE_ON_OUT)
		else $error("switch driven in shutdown");
	c_flag_good: cover property ($fell(POWER_OK_FLAG_OE_OUT));
	c_ext_lock: cover property ($rose(EXT_SYNC_OUT));
	c_trip: cover property ($fell(HIGH_SIDE_ON_OUT) && SWITCH_OE_OUT);
endmodule
bind power_good_top power_good_sva u_power_good_sva (.CORE_CLK_IN, .RESETN_IN, .FEEDBACK_SENSE_IN,
	.SYNC_IN, .SHUTDOWN_N_IN, .UVLO_CLEAR_IN, .CURRENT_TRIP_IN, .POWER_OK_FLAG_O_OUT,
	.POWER_OK_FLAG_OE_OUT, .INVERTED_CLOCK_O_OUT, .INVERTED_CLOCK_OE_OUT, .HIGH_SIDE_ON_OUT,
	.SWITCH_OE_OUT, .EXT_SYNC_OUT);
`default_nettype wire

// ---- verification/board_partner.sv ----
// board model: sync source and pull-ups on the open-drain pins
// controlled by tb_top; strap level holds while not toggling
`timescale 1ns/1ns
`default_nettype none
module board_partner (
	input  wire logic strap_in,
	input  wire logic toggle_in,
	input  var  int   half_ns_in,
	input  wire logic flag_o_in,
	input  wire logic flag_oe_in,
	input  wire logic clk_o_in,
	input  wire logic clk_oe_in,
	output wire logic sync_out,
	output wire logic good_out,
	output wire logic ref_n_out
);
	// ----
	// sync source
	// ----
	logic tog;
	// 1 ns polling keeps train edges off the rising clock edge
	initial begin
		tog = 1'b0;
		forever begin
			if (toggle_in) #(half_ns_in) tog = ~tog;
			else #1 tog = strap_in;
		end
	end
	assign sync_out = toggle_in ? tog : strap_in;
	// pull-ups: released flag frees the downstream shutdown input
	assign good_out = flag_oe_in ? flag_o_in : 1'b1;
	assign ref_n_out = clk_oe_in ? clk_o_in : 1'b1;
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking bench for power_good_top with the board model
// one 125 MHz clock; inputs change on the falling edge
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import power_ok_flag_pkg::*;
;
	logic               clk, rst_n, strap, tog, shdn_n, uvlo, trip;
	logic [SENSE_W-1:0] sense;
	logic               sync_w, good_w, ref_n_w, fo, foe, co, coe, hs, ls, soe, ext;
	int                 half_ns, err_total, comparisons, p;
	power_good_top u_power_good_top (.CORE_CLK_IN(clk), .RESETN_IN(rst_n), .FEEDBACK_SENSE_IN(sense),
		.SYNC_IN(sync_w), .SHUTDOWN_N_IN(shdn_n), .UVLO_CLEAR_IN(uvlo), .CURRENT_TRIP_IN(trip),
		.POWER_OK_FLAG_O_OUT(fo), .POWER_OK_FLAG_OE_OUT(foe), .INVERTED_CLOCK_O_OUT(co),
		.INVERTED_CLOCK_OE_OUT(coe), .HIGH_SIDE_ON_OUT(hs), .LOW_SIDE_ON_OUT(ls),
		.SWITCH_OE_OUT(soe), .EXT_SYNC_OUT(ext));
	board_partner u_board_partner (.strap_in(strap), .toggle_in(tog), .half_ns_in(half_ns),
		.flag_o_in(fo), .flag_oe_in(foe), .clk_o_in(co), .clk_oe_in(coe),
		.sync_out(sync_w), .good_out(good_w), .ref_n_out(ref_n_w));
	// ----
	// helpers
	// ----
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s exp %0h got %0h", nm, exp, got);
		end
	endtask
	task automatic cyc(input int n); repeat (n) @(negedge clk); endtask
	task automatic per(input int n); cyc(n * OSC_FAST_CYC); endtask
	// cycles between two reference rises; ends just after the second
	task automatic period(output int c);
		for (int i = 0; i < 2; i++) begin
			c = 0;
			while (ref_n_w !== 1'b1 && c < 3000) begin @(negedge clk); c++; end
			while (ref_n_w !== 1'b0 && c < 6000) begin @(negedge clk); c++; end
		end
	endtask
	task automatic test_done();
		if (err_total == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_reset();
		cyc(8);
		chk("flag_oe_rst", 1'b1, foe);
		chk("switch_oe_rst", 1'b0, soe);
	endtask
	// a short exit mid-count restarts it; entry at the 1100 mV edge
	task automatic t_qualify();
		sense = 12'h3e8;
		per(30);
		sense = 12'h320;
		cyc(4);
		sense = 12'h44c;
		per(60);
		chk("flag_restart", 1'b0, good_w);
		per(6);
		chk("flag_good", 1'b1, good_w);
	endtask
	// hysteresis band holds, a short return restarts the exit count
	task automatic t_exit();
		sense = 12'h460;
		per(66);
		chk("flag_hyst", 1'b1, good_w);
		sense = 12'h4b0;
		per(60);
		sense = 12'h3e8;
		cyc(4);
		sense = 12'h4b0;
		per(60);
		chk("flag_held", 1'b1, good_w);
		per(6);
		chk("flag_dropped", 1'b0, good_w);
	endtask
	task automatic t_clock();
		period(p);
		chk("fast_period", OSC_FAST_CYC, p);
		strap = 1'b0;
		cyc(4400);
		period(p);
		chk("slow_period", OSC_SLOW_CYC, p);
		chk("int_mode", 1'b0, ext);
		strap = 1'b1;
		cyc(300);
	endtask
	// lock to a 50-cycle train, drop on silence, refuse a too-fast one
	task automatic t_sync();
		half_ns = 200;
		tog = 1'b1;
		cyc(400);
		chk("ext_lock", 1'b1, ext);
		period(p);
		chk("ext_period", 32'd50, p);
		tog = 1'b0;
		cyc(1300);
		chk("ext_drop", 1'b0, ext);
		half_ns = 80;
		tog = 1'b1;
		cyc(400);
		chk("ext_too_fast", 1'b0, ext);
		tog = 1'b0;
	endtask
	task automatic t_shutdown();
		sense = 12'h3e8;
		per(66);
		chk("flag_before_off", 1'b1, good_w);
		shdn_n = 1'b0;
		cyc(8);
		chk("flag_off", 1'b0, good_w);
		chk("switch_off", 1'b0, soe);
		shdn_n = 1'b1;
		per(2);
		chk("switch_on", 1'b1, soe);
		per(58);
		chk("flag_requal", 1'b0, good_w);
		uvlo = 1'b0;
		cyc(8);
		chk("switch_uvlo", 1'b0, soe);
		uvlo = 1'b1;
	endtask
	// trip inside a high phase so no reference fall overlaps it
	task automatic t_trip();
		per(2);
		period(p);
		cyc(1);
		trip = 1'b1;
		cyc(6);
		chk("trip_high_off", 1'b0, hs);
		chk("trip_low_on", 1'b1, ls);
		trip = 1'b0;
		per(2);
		chk("next_cycle_on", 1'b1, hs);
	endtask
	initial begin
		rst_n = 1'b0;
		strap = 1'b1;
		tog = 1'b0;
		half_ns = 200;
		shdn_n = 1'b1;
		uvlo = 1'b1;
		trip = 1'b0;
		sense = 12'h000;
		err_total = 0;
		comparisons = 0;
		t_reset();
		cyc(8);
		rst_n = 1'b1;
		t_qualify();
		t_exit();
		t_clock();
		t_sync();
		t_shutdown();
		t_trip();
		test_done();
	end
	// the planned run is near 60000 cycles
	initial begin
		repeat (90000) @(posedge clk);
		err_total++;
		test_done();
	end
endmodule
`default_nettype wire
